/* irqp_pkg.sv */
// Package with the register map, field positions and sizes of the priority and enable slice.
package irqp_pkg;
	localparam int NUM_CORE = 7;
	localparam int NUM_EXT = 8;
	localparam int NUM_SRC = NUM_CORE + NUM_EXT;
	localparam int VEC_W = 4;
	localparam logic [7:0] ADDR_PRIO_HIGH = 8'h84;
	localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8;
	localparam logic [7:0] ADDR_EXT_ENABLE_ONE = 8'he6;
	localparam logic [6:0] PRIO_LOW_RESET = 7'h00;
	localparam logic [6:0] PRIO_HIGH_RESET = 7'h00;
	localparam logic [7:0] EXT_ENABLE_RESET = 8'h00;
	localparam logic UNUSED_READ_VALUE = 1'b1;
	localparam int UNUSED_BIT = 7;
	localparam int SERIAL_PERIPH_BIT = 6;
	localparam int TIMER_TWO_BIT = 5;
	localparam int UART_BIT = 4;
	localparam int TIMER_ONE_BIT = 3;
	localparam int EXT_ONE_BIT = 2;
	localparam int TIMER_ZERO_BIT = 1;
	localparam int EXT_ZERO_BIT = 0;
	localparam int TIMER_THREE_EN_BIT = 7;
	localparam int RESERVED_EN_BIT = 6;
	localparam int COMPARATOR_EN_BIT = 5;
	localparam int COUNTER_ARRAY_EN_BIT = 4;
	localparam int ADC_DONE_EN_BIT = 3;
	localparam int ADC_WINDOW_EN_BIT = 2;
	localparam int PORT_MATCH_EN_BIT = 1;
	localparam int SMBUS_ZERO_EN_BIT = 0;
endpackage : irqp_pkg

/* irqp_resolver.sv */
// Combinational search for the highest priority pending source, lowest vector on a tie.
`timescale 1ns/100ps
`default_nettype none
module irqp_resolver #(
	parameter int NUM = 15,
	parameter int IDW = 4
) (
	input wire logic [NUM-1:0] pending, // Masked requests, one per vector.
	input wire logic [2*NUM-1:0] levels, // Two-bit level per vector, vector 0 lowest.
	output logic found, // Some request is pending.
	output logic [IDW-1:0] bestId, // Vector of the winner.
	output logic [1:0] bestLevel // Level of the winner.
);
	always_comb
	begin
		found = 1'b0;
		bestId = '0;
		bestLevel = 2'b00;
		// Walking downward with >= lets the lowest vector win among equal levels.
		for (int i = NUM - 1; i >= 0; i--)
		begin
			if (pending[i] && (!found || levels[2*i +: 2] >= bestLevel))
			begin
				found = 1'b1;
				bestId = IDW'(i);
				bestLevel = levels[2*i +: 2];
			end
		end
	end
endmodule : irqp_resolver
`default_nettype wire

/* irqp_regs.sv */
// Interrupt priority low and high registers, first extended enable register and request selection.
//
// Notes on behaviour
// R01: Top bit of both priority registers reads one and ignores writes.
// R02: Priority-low bits 6..0: serial, timer 2, UART, timer 1, ext 1, timer 0, ext 0.
// R03: Priority-high bits 6..0 give the upper priority bit, same order.
// R04: Extended enable bit 7 passes timer 3 low or high overflow requests.
// R05: Extended enable bit 5 passes comparator rise or fall requests.
// R06: Extended enable bit 4 gates every counter array request.
// R07: Extended enable bit 3 gates the ADC conversion-done request.
// R08: Extended enable bit 2 gates the ADC window-compare request.
// R09: Extended enable bit 1 gates port match requests.
// R10: Extended enable bit 0 gates first SMBus requests.
// R11: Software writes zero to extended enable bit 6.
// R12: Priority registers sit at 0xB8 and 0x84 and accept single-bit writes.
// R13: Global enable clear blocks every source; set lets each mask decide.
// R14: Level is high bit then low bit; higher level preempts lower service.
// R15: All priority and enable bits are zero after reset.
`timescale 1ns/100ps
`default_nettype none
module irqp_regs #(
	parameter int NUM_CORE = irqp_pkg::NUM_CORE,
	parameter int NUM_EXT = irqp_pkg::NUM_EXT
) (
	input wire logic core_clk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic [7:0] sfrAddr, // Special-function register address, same on every page.
	input wire logic sfrWrite, // Byte write strobe.
	input wire logic [7:0] sfrWdata, // Byte write data.
	input wire logic sfrRead, // Byte read strobe.
	input wire logic bitWrite, // Single-bit write strobe at sfrAddr.
	input wire logic [2:0] bitIndex, // Bit position of a single-bit write.
	input wire logic bitValue, // Value of a single-bit write.
	output logic [7:0] sfrRdata, // Read data, valid the cycle after sfrRead.
	input wire logic globalIrqEnable, // Global enable from the core enable register.
	input wire logic [NUM_CORE-1:0] coreReq, // Core source requests, vector order.
	input wire logic [NUM_CORE-1:0] coreEnable, // Core source individual enables.
	input wire logic timerThreeLowOverflow, // Timer 3 low overflow flag.
	input wire logic timerThreeHighOverflow, // Timer 3 high overflow flag.
	input wire logic comparatorRiseFlag, // Comparator rising edge flag.
	input wire logic comparatorFallFlag, // Comparator falling edge flag.
	input wire logic counterArrayReq, // Any counter array request.
	input wire logic adcDoneFlag, // ADC conversion done flag.
	input wire logic adcWindowFlag, // ADC window compare flag.
	input wire logic portMatchReq, // Port match event.
	input wire logic smbusZeroReq, // First SMBus request.
	input wire logic [2*NUM_EXT-1:0] extPrio, // Levels of extended sources, by enable bit.
	input wire logic serviceActive, // Core is inside a handler.
	input wire logic [1:0] serviceLevel, // Level of the handler in service.
	output logic irqRequest, // Request to the core, level.
	output logic [irqp_pkg::VEC_W-1:0] irqVector, // Vector number of the request.
	output logic [1:0] irqLevel, // Level of the request.
	output logic [7:0] extEnableOut // Current extended enable register.
);
	localparam int NUM_SRC = NUM_CORE + NUM_EXT;

	logic [NUM_CORE-1:0] prioLow_reg;
	logic [NUM_CORE-1:0] prioHigh_reg;
	logic [7:0] extEnable_reg;
	logic [7:0] sfrRdata_reg;
	logic irqRequest_reg;
	logic [irqp_pkg::VEC_W-1:0] irqVector_reg;
	logic [1:0] irqLevel_reg;
	logic [NUM_EXT-1:0] extRaw;
	logic [NUM_EXT-1:0] extPending;
	logic [NUM_CORE-1:0] corePending;
	logic [NUM_SRC-1:0] allPending;
	logic [2*NUM_SRC-1:0] allLevels;
	logic found;
	logic [irqp_pkg::VEC_W-1:0] bestId;
	logic [1:0] bestLevel;
	logic hitLow;
	logic hitHigh;
	logic hitExt;

	assign hitLow = (sfrAddr == irqp_pkg::ADDR_PRIO_LOW); // [R12]
	assign hitHigh = (sfrAddr == irqp_pkg::ADDR_PRIO_HIGH); // [R12]
	assign hitExt = (sfrAddr == irqp_pkg::ADDR_EXT_ENABLE_ONE);

	// Byte writes drop bit 7; single-bit writes to bit 7 are ignored.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prioLow_reg <= irqp_pkg::PRIO_LOW_RESET; // [R15]
		end
		else if (sfrWrite && hitLow)
		begin
			prioLow_reg <= sfrWdata[NUM_CORE-1:0]; // [R01] [R02]
		end
		else if (bitWrite && hitLow && bitIndex != 3'(irqp_pkg::UNUSED_BIT))
		begin
			prioLow_reg[bitIndex] <= bitValue; // [R12]
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prioHigh_reg <= irqp_pkg::PRIO_HIGH_RESET; // [R15]
		end
		else if (sfrWrite && hitHigh)
		begin
			prioHigh_reg <= sfrWdata[NUM_CORE-1:0]; // [R01] [R03]
		end
		else if (bitWrite && hitHigh && bitIndex != 3'(irqp_pkg::UNUSED_BIT))
		begin
			prioHigh_reg[bitIndex] <= bitValue; // [R12]
		end
	end

	// The extended enable register is not bit-addressable; only byte writes land.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			extEnable_reg <= irqp_pkg::EXT_ENABLE_RESET; // [R15]
		end
		else if (sfrWrite && hitExt)
		begin
			extEnable_reg <= sfrWdata;
		end
	end

	// Unmapped addresses read as zero.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sfrRdata_reg <= 8'h00;
		end
		else if (sfrRead)
		begin
			if (hitLow)
			begin
				sfrRdata_reg <= {irqp_pkg::UNUSED_READ_VALUE, prioLow_reg}; // [R01]
			end
			else if (hitHigh)
			begin
				sfrRdata_reg <= {irqp_pkg::UNUSED_READ_VALUE, prioHigh_reg}; // [R01]
			end
			else if (hitExt)
			begin
				sfrRdata_reg <= extEnable_reg;
			end
			else
			begin
				sfrRdata_reg <= 8'h00;
			end
		end
	end

	// Raw extended requests in enable-bit order; the reserved position never requests.
	always_comb
	begin
		extRaw = '0;
		extRaw[irqp_pkg::TIMER_THREE_EN_BIT] = timerThreeLowOverflow | timerThreeHighOverflow;
		extRaw[irqp_pkg::COMPARATOR_EN_BIT] = comparatorRiseFlag | comparatorFallFlag;
		extRaw[irqp_pkg::COUNTER_ARRAY_EN_BIT] = counterArrayReq;
		extRaw[irqp_pkg::ADC_DONE_EN_BIT] = adcDoneFlag;
		extRaw[irqp_pkg::ADC_WINDOW_EN_BIT] = adcWindowFlag;
		extRaw[irqp_pkg::PORT_MATCH_EN_BIT] = portMatchReq;
		extRaw[irqp_pkg::SMBUS_ZERO_EN_BIT] = smbusZeroReq;
	end

	// Each extended enable bit gates its own source. [R04] [R05] [R06] [R07] [R08] [R09] [R10]
	assign extPending = extRaw & extEnable_reg & {NUM_EXT{globalIrqEnable}}; // [R13]
	assign corePending = coreReq & coreEnable & {NUM_CORE{globalIrqEnable}}; // [R13]
	assign allPending = {extPending, corePending};

	// Extended bit b maps to vector NUM_CORE + b.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_level
			if (gi < NUM_CORE)
			begin : g_core
				assign allLevels[2*gi +: 2] = {prioHigh_reg[gi], prioLow_reg[gi]}; // [R14]
			end
			else
			begin : g_ext
				assign allLevels[2*gi +: 2] = extPrio[2*(gi-NUM_CORE) +: 2];
			end
		end
	endgenerate

	irqp_resolver #(
		.NUM(NUM_SRC),
		.IDW(irqp_pkg::VEC_W)
	) u_resolver (
		.pending(allPending),
		.levels(allLevels),
		.found(found),
		.bestId(bestId),
		.bestLevel(bestLevel)
	);

	// A handler in service is only interrupted by a strictly higher level.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irqRequest_reg <= 1'b0;
			irqVector_reg <= '0;
			irqLevel_reg <= 2'b00;
		end
		else
		begin
			irqRequest_reg <= found && (!serviceActive || bestLevel > serviceLevel); // [R14]
			irqVector_reg <= bestId;
			irqLevel_reg <= bestLevel;
		end
	end

	assign sfrRdata = sfrRdata_reg;
	assign irqRequest = irqRequest_reg;
	assign irqVector = irqVector_reg;
	assign irqLevel = irqLevel_reg;
	assign extEnableOut = extEnable_reg;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	property p_unused_reads_one;
		sfrRead && (hitLow || hitHigh) |=> sfrRdata[7];
	endproperty
	a_unused_reads_one: assert property (p_unused_reads_one) // [R01]
		else $error("Unused priority bit did not read one.");

	property p_low_write;
		sfrWrite && hitLow |=> prioLow_reg == $past(sfrWdata[6:0]);
	endproperty
	a_low_write: assert property (p_low_write) // [R02]
		else $error("Priority-low byte write not stored.");

	property p_high_write_readback;
		sfrWrite && hitHigh ##1 sfrRead && hitHigh && !sfrWrite && !bitWrite
			|=> sfrRdata == {1'b1, $past(sfrWdata[6:0], 2)};
	endproperty
	a_high_write_readback: assert property (p_high_write_readback) // [R03]
		else $error("Priority-high readback differs from written byte.");

	property p_bit_write;
		bitWrite && !sfrWrite && hitHigh && bitIndex != 3'd7
			|=> prioHigh_reg[$past(bitIndex)] == $past(bitValue);
	endproperty
	a_bit_write: assert property (p_bit_write) // [R12]
		else $error("Single-bit write to priority-high not applied.");

	property p_global_block;
		!globalIrqEnable |=> !irqRequest;
	endproperty
	a_global_block: assert property (p_global_block) // [R13]
		else $error("Request raised while global enable clear.");

	property p_timer_three_gate;
		irqRequest && irqVector == 4'd14 |-> $past(extEnable_reg[7]);
	endproperty
	a_timer_three_gate: assert property (p_timer_three_gate) // [R04]
		else $error("Timer 3 request passed with its enable clear.");

	property p_comparator_gate;
		irqRequest && irqVector == 4'd12 |-> $past(extEnable_reg[5]);
	endproperty
	a_comparator_gate: assert property (p_comparator_gate) // [R05]
		else $error("Comparator request passed with its enable clear.");

	property p_smbus_gate;
		irqRequest && irqVector == 4'd7 |-> $past(extEnable_reg[0]);
	endproperty
	a_smbus_gate: assert property (p_smbus_gate) // [R10]
		else $error("SMBus request passed with its enable clear.");

	property p_counter_array_gate;
		irqRequest && irqVector == 4'd11 |-> $past(extEnable_reg[4]);
	endproperty
	a_counter_array_gate: assert property (p_counter_array_gate) // [R06]
		else $error("Counter array request passed with its enable clear.");

	property p_adc_done_gate;
		irqRequest && irqVector == 4'd10 |-> $past(extEnable_reg[3]);
	endproperty
	a_adc_done_gate: assert property (p_adc_done_gate) // [R07]
		else $error("ADC done request passed with its enable clear.");

	property p_port_match_gate;
		irqRequest && irqVector == 4'd8 |-> $past(extEnable_reg[1]);
	endproperty
	a_port_match_gate: assert property (p_port_match_gate) // [R09]
		else $error("Port match request passed with its enable clear.");

	property p_preempt;
		irqRequest && $past(serviceActive) |-> irqLevel > $past(serviceLevel);
	endproperty
	a_preempt: assert property (p_preempt) // [R14]
		else $error("Request did not outrank the level in service.");

	property p_core_level;
		irqRequest && irqVector == 4'd6 |-> irqLevel == $past({prioHigh_reg[6], prioLow_reg[6]});
	endproperty
	a_core_level: assert property (p_core_level) // [R14]
		else $error("Serial peripheral level not formed from its two bits.");

	c_preempt: cover property (serviceActive ##1 irqRequest);
	c_bit_write: cover property (bitWrite && hitLow);
	c_ext_request: cover property (irqRequest && irqVector >= 4'd7);
endmodule : irqp_regs
`default_nettype wire

/* irqp_core_model.sv */
// Behavioural model of the core that takes a request into service and later returns from it.
`timescale 1ns/100ps
`default_nettype none
module irqp_core_model (
	input wire logic core_clk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic irqRequest, // Request from the slice.
	input wire logic [1:0] irqLevel, // Level of the request.
	input wire logic takeEn, // Allows the model to enter a handler.
	input wire logic doneEn, // Makes the model leave its handler.
	output logic serviceActive, // Inside a handler.
	output logic [1:0] serviceLevel // Level of that handler.
);
	// A handler is entered at the level of the request it accepted.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			serviceActive <= 1'b0;
			serviceLevel <= 2'h0;
		end
		else if (doneEn)
			serviceActive <= 1'b0;
		else if (takeEn && irqRequest && !serviceActive)
		begin
			serviceActive <= 1'b1;
			serviceLevel <= irqLevel;
		end
	end
endmodule : irqp_core_model
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench of the priority and enable register slice.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0, rstn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, bitWrite = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, extEnableOut;
	logic [2:0] bitIndex = 3'h0;
	logic bitValue = 1'b0, globalIrqEnable = 1'b0, takeEn = 1'b0, doneEn = 1'b0;
	logic [6:0] coreReq = 7'h00, coreEnable = 7'h00;
	logic [8:0] extSrc = 9'h000;
	logic [15:0] extPrio = 16'h0000;
	logic serviceActive, irqRequest;
	logic [1:0] serviceLevel, irqLevel;
	logic [3:0] irqVector;
	int errorCnt = 0, nTests = 0, cycles = 0;
	int enB[9] = '{7, 7, 5, 5, 4, 3, 2, 1, 0};
	irqp_regs DUT (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
		.sfrWdata(sfrWdata), .sfrRead(sfrRead), .bitWrite(bitWrite), .bitIndex(bitIndex),
		.bitValue(bitValue), .sfrRdata(sfrRdata), .globalIrqEnable(globalIrqEnable),
		.coreReq(coreReq), .coreEnable(coreEnable), .timerThreeLowOverflow(extSrc[0]),
		.timerThreeHighOverflow(extSrc[1]), .comparatorRiseFlag(extSrc[2]),
		.comparatorFallFlag(extSrc[3]), .counterArrayReq(extSrc[4]), .adcDoneFlag(extSrc[5]),
		.adcWindowFlag(extSrc[6]), .portMatchReq(extSrc[7]), .smbusZeroReq(extSrc[8]),
		.extPrio(extPrio), .serviceActive(serviceActive), .serviceLevel(serviceLevel),
		.irqRequest(irqRequest), .irqVector(irqVector), .irqLevel(irqLevel),
		.extEnableOut(extEnableOut));
	irqp_core_model core (.core_clk(core_clk), .rstn(rstn), .irqRequest(irqRequest),
		.irqLevel(irqLevel), .takeEn(takeEn), .doneEn(doneEn), .serviceActive(serviceActive),
		.serviceLevel(serviceLevel));
	initial
	begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errorCnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			errorCnt++;
		end
	endtask : chk
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	// Each access ends with one idle edge, so a strobe never falls and rises in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1'b1;
		tick();
		sfrWrite = 1'b0;
		tick();
	endtask : wr
	task automatic bwr(input logic [7:0] a, input logic [2:0] i, input logic v);
		sfrAddr = a;
		bitIndex = i;
		bitValue = v;
		bitWrite = 1'b1;
		tick();
		bitWrite = 1'b0;
		tick();
	endtask : bwr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfrAddr = a;
		sfrRead = 1'b1;
		tick();
		sfrRead = 1'b0;
		chk(sfrRdata, exp);
		tick();
	endtask : rd
	// A byte write followed at the very next edge by a read of the same address.
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1'b1;
		tick();
		sfrWrite = 1'b0;
		sfrRead = 1'b1;
		tick();
		sfrRead = 1'b0;
		chk(sfrRdata, exp);
		tick();
	endtask : wr_rd
	// Checks the registered request two clock edges after the inputs have been set.
	task automatic req(input logic r, input logic [3:0] v, input logic [1:0] l);
		tick();
		tick();
		chk({7'h00, irqRequest}, {7'h00, r});
		if (r)
		begin
			chk({4'h0, irqVector}, {4'h0, v});
			chk({6'h00, irqLevel}, {6'h00, l});
		end
	endtask : req
	initial
	begin
		repeat (2) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		rd(8'hb8, 8'h80);
		rd(8'h84, 8'h80);
		rd(8'he6, 8'h00);
		wr(8'hb8, 8'h00);
		rd(8'hb8, 8'h80);
		wr_rd(8'h84, 8'h7f, 8'hff);
		bwr(8'h84, 3'h7, 1'b0);
		bwr(8'h84, 3'h2, 1'b0);
		rd(8'h84, 8'hfb);
		wr(8'h84, 8'h00);
		bwr(8'hb8, 3'h3, 1'b1);
		rd(8'hb8, 8'h88);
		rd(8'h5a, 8'h00);
		wr(8'he6, 8'hbf);
		rd(8'he6, 8'hbf);
		chk(extEnableOut, 8'hbf);
		$display("test registers done");
		globalIrqEnable = 1'b1;
		coreReq = 7'h7f;
		coreEnable = 7'h7f;
		wr(8'he6, 8'h00);
		for (int i = 0; i < 7; i++)
		begin
			wr(8'hb8, 8'(1 << i));
			req(1'b1, 4'(i), 2'b01);
			wr(8'hb8, 8'h00);
			wr(8'h84, 8'(1 << i));
			req(1'b1, 4'(i), 2'b10);
			wr(8'h84, 8'h00);
		end
		globalIrqEnable = 1'b0;
		req(1'b0, 4'h0, 2'b00);
		globalIrqEnable = 1'b1;
		$display("test core priority done");
		wr(8'hb8, 8'h08);
		takeEn = 1'b1;
		req(1'b0, 4'h0, 2'b00);
		takeEn = 1'b0;
		wr(8'h84, 8'h08);
		req(1'b1, 4'h3, 2'b11);
		doneEn = 1'b1;
		tick();
		doneEn = 1'b0;
		wr(8'hb8, 8'h00);
		wr(8'h84, 8'h00);
		coreEnable = 7'h00;
		$display("test preemption done");
		for (int k = 0; k < 9; k++)
		begin
			wr(8'he6, 8'(1 << enB[k]));
			extSrc = 9'(1 << k);
			extPrio = 16'(2 << (2 * enB[k]));
			req(1'b1, 4'(7 + enB[k]), 2'b10);
			wr(8'he6, 8'hbf & ~8'(1 << enB[k]));
			req(1'b0, 4'h0, 2'b00);
			globalIrqEnable = 1'b0;
			wr(8'he6, 8'(1 << enB[k]));
			req(1'b0, 4'h0, 2'b00);
			globalIrqEnable = 1'b1;
			extSrc = 9'h000;
		end
		$display("test extended enables done");
		coreEnable = 7'h7f;
		wr(8'hb8, 8'h7f);
		wr(8'he6, 8'hbf);
		rstn = 1'b0;
		tick();
		chk({7'h00, irqRequest}, 8'h00);
		rstn = 1'b1;
		rd(8'hb8, 8'h80);
		rd(8'he6, 8'h00);
		chk(extEnableOut, 8'h00);
		$display("test reset done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
